// ---- sim/taeu_mem_model.sv ----
// taeu_mem_model: byte memory behind the exec unit's memory port
// assumes one clock; each request is answered after a random 0..3 cycle stall
`timescale 1ns/1ps
module taeu_mem_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic mem_word,
   input wire logic [15:0] mem_wdata,
   output logic [15:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] mem [logic [19:0]];
   int stall;

   // one ack pulse per request; idle data keeps toggling so a stale read shows
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h5a5a;
         stall = 0;
      end else if (mem_ack || !(mem_rd || mem_wr) || stall > 0) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         stall = mem_ack ? $urandom % 4 : stall - (mem_rd || mem_wr);
      end else begin
         mem_ack <= 1'b1;
         if (mem_wr)
            mem[mem_addr] = mem_wdata[7:0];
         if (mem_wr && mem_word)
            mem[mem_addr + 20'h1] = mem_wdata[15:8];
         if (mem_rd)
            mem_rdata <= mem_word ? {mem[mem_addr + 20'h1], mem[mem_addr]} :
                                    {~mem[mem_addr], mem[mem_addr]};
      end
   end
endmodule : taeu_mem_model

// ---- sim/testbench.sv ----
// testbench: drives the exec unit over apb, checks results, flags and memory
// assumes the memory model answers block transfers on the same clock
`timescale 1ns/1ps
module testbench;
   import taeu_pkg::*;
   logic mclk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
   logic mem_rd, mem_wr, mem_word, mem_ack;
   logic [ADDR_W-1:0] paddr;
   logic [MADDR_W-1:0] mem_addr;
   logic [31:0] pwdata, prdata, rd_val;
   logic [15:0] mem_wdata, mem_rdata;
   logic [33:0] notes [$];
   int n_fail, num_checks;

   taeu_core i_taeu_core (.mclk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .mem_addr, .mem_rd, .mem_wr, .mem_word, .mem_wdata,
      .mem_rdata, .mem_ack);
   taeu_mem_model i_taeu_mem_model (.mclk, .rst_n, .mem_addr, .mem_rd, .mem_wr,
      .mem_word, .mem_wdata, .mem_rdata, .mem_ack);

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict();
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   // clock and watchdog; the run needs well under 10000 cycles
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      #1_000_000;
      n_fail++;
      give_verdict();
   end

   // each finished transfer takes the oldest note; writes answer with pslverr only
   always @(posedge mclk) begin
      logic [33:0] nt;
      if (psel && penable && pready && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt[33])
            check({pslverr, pwrite ? 32'h0 : prdata}, nt[32:0]);
      end
   end

   // one apb transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic chk, input logic [32:0] exp);
      int n;
      notes.push_back({chk, exp});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      // a transfer that never completes counts against the run
      if (pready !== 1'b1)
         n_fail++;
      rd_val = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b1, {1'b0, e});
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 33'h0);
   endtask : wr

   // poll status until idle with done set
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_STAT, 32'h0, 1'b0, 33'h0);
         n++;
      end while (rd_val[1:0] !== 2'b10 && n < 100);
      // a command that never finishes counts against the run
      if (rd_val[1:0] !== 2'b10)
         n_fail++;
   endtask : wait_done

   task automatic run(input logic w, input logic [4:0] op, input logic [31:0] a, b);
      wr(OFS_OPA, a);
      wr(OFS_OPB, b);
      apb(1'b1, OFS_CMD, {23'h0, w, 3'h0, op}, 1'b1, 33'h0);
      wait_done();
   endtask : run

   function automatic logic [15:0] i2bcd(input int x);
      return {4'(x / 1000), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
   endfunction : i2bcd

   // divisor-sign variant moves a nonzero remainder over to the divisor's sign
   function automatic logic [31:0] dref(input logic x, input logic w, input int n, d);
      int q, r;
      q = n / d;
      r = n - q * d;
      if (x && r != 0 && (r < 0) != (d < 0)) begin
         q--;
         r += d;
      end
      return w ? {16'(r), 16'(q)} : {16'h0, 8'(r), 8'(q)};
   endfunction : dref

   initial begin
      logic [31:0] a, b, e;
      logic [3:0] f;
      logic w, c, cy;
      int n, d, r, m;
      int dn [6] = '{33, 33, -33, -33, 0, 33};
      int dd [6] = '{-4, -4, 4, 4, 0, 0};
      logic [4:0] dop [6] = '{OP_DIV_S, OP_DIV_X, OP_DIV_S, OP_DIV_X, OP_DIV_U, OP_DIV_U};
      void'($urandom(32'he46a));
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      rst_n = 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      apb(1'b0, 8'h2c, 32'h0, 1'b1, {1'b1, 32'h0});
      // nibble moves over random bytes
      for (int k = 0; k < 4; k++) begin
         a = $urandom % 256;
         b = $urandom % 256;
         run(1'b0, 5'(k), a, b); // operand pair keeps the low data byte in play
         e = k == 0 ? {a[7:4], b[3:0]} : k == 1 ? {b[7:4], a[7:4]} :
             k == 2 ? {a[3:0], b[3:0]} : {b[7:4], a[3:0]};
         rd(OFS_RES, e);
      end
      // conditional stores with the zero flag clear and set
      for (int k = 0; k < 6; k++) begin
         a = $urandom % 256; // 8-bit immediate sources only
         b = $urandom % 256;
         f = {2'b00, k[0], 1'b0};
         wr(OFS_FLG, f);
         run(1'b0, 5'(4 + k / 2), a, b);
         rd(OFS_RES, ((k / 2 == 1) != k[0]) ? a : b);
         rd(OFS_FLG, f);
      end
      // products at both sizes; random flags must survive
      for (int k = 0; k < 4; k++) begin
         a = $urandom % (k[1] ? 65536 : 256);
         b = $urandom % (k[1] ? 65536 : 256);
         f = $urandom;
         wr(OFS_FLG, f);
         run(k[1], k[0] ? OP_MUL_U : OP_MUL_S, a, b); // no address registers
         n = k[0] ? a : k[1] ? 32'($signed(a[15:0])) : 32'($signed(a[7:0]));
         d = k[0] ? b : k[1] ? 32'($signed(b[15:0])) : 32'($signed(b[7:0]));
         e = n * d;
         rd(OFS_RES, k[1] ? e : e & 32'hffff);
         rd(OFS_FLG, f);
      end
      // divides: remainder sign conventions, random unsigned, zero divisor last
      for (int k = 0; k < 6; k++) begin
         w = k > 1 && k < 5;
         if (k == 4) begin
            dn[4] = $urandom % 32'h7fffffff;
            dd[4] = dn[4] / 65536 + 1;
         end
         wr(OFS_FLG, 32'h7);
         run(w, dop[k], dd[k] & (w ? 32'hffff : 32'hff), w ? dn[k] : dn[k] & 32'hffff);
         if (dd[k] != 0)
            e = dref(dop[k] == OP_DIV_X, w, dn[k], dd[k]);
         rd(OFS_RES, e);
         rd(OFS_FLG, dd[k] != 0 ? 32'h7 : 32'hf);
      end
      // decimal add and subtract at both sizes, carry in either state
      for (int k = 0; k < 8; k++) begin
         w = k[2];
         m = w ? 10000 : 100;
         n = $urandom % m;
         d = $urandom % m;
         c = $urandom;
         wr(OFS_FLG, {1'b1, 2'b00, c});
         run(w, 5'(15 + k % 4), i2bcd(n), i2bcd(d));
         r = k % 4 < 2 ? d + n + (k % 4 == 1 ? c : 0) : d - n - (k % 4 == 3 ? !c : 0);
         cy = k % 4 < 2 ? r >= m : r >= 0;
         e = i2bcd((r + m) % m);
         rd(OFS_RES, e);
         rd(OFS_FLG, {1'b1, w ? e[15] : e[7], e == 0, cy});
      end
      // byte copy up from a banked source
      for (int i = 0; i < 8; i++)
         i_taeu_mem_model.mem[20'h10100 + i] = $urandom;
      wr(OFS_BANK, 32'h1); // pointers and count loaded before the command
      wr(OFS_A0, 32'h0100);
      wr(OFS_A1, 32'h0200);
      wr(OFS_CNT, 32'h3);
      run(1'b0, OP_COPY_UP, 32'h0, 32'h0);
      rd(OFS_A0, 32'h0103);
      rd(OFS_A1, 32'h0203);
      rd(OFS_CNT, 32'h0);
      for (int i = 0; i < 3; i++)
         check({25'h0, i_taeu_mem_model.mem[20'h200 + i]},
               {25'h0, i_taeu_mem_model.mem[20'h10100 + i]});
      // word copy down; a write while busy is refused and leaves flags alone
      wr(OFS_FLG, 32'h0);
      wr(OFS_A0, 32'h0105);
      wr(OFS_A1, 32'h0305);
      wr(OFS_CNT, 32'h2);
      apb(1'b1, OFS_CMD, {23'h0, 1'b1, 3'h0, OP_COPY_DN}, 1'b1, 33'h0);
      apb(1'b1, OFS_FLG, 32'hf, 1'b1, {1'b1, 32'h0});
      wait_done();
      rd(OFS_FLG, 32'h0);
      rd(OFS_A0, 32'h0101);
      rd(OFS_A1, 32'h0301);
      for (int i = 3; i < 7; i++)
         check({25'h0, i_taeu_mem_model.mem[20'h300 + i]},
               {25'h0, i_taeu_mem_model.mem[20'h10100 + i]});
      // word fill up, then a fill with a zero count moves nothing
      wr(OFS_R0, 32'hbeef);
      wr(OFS_A1, 32'h0400);
      wr(OFS_CNT, 32'h2);
      run(1'b1, OP_FILL_UP, 32'h0, 32'h0);
      rd(OFS_A1, 32'h0404);
      for (int i = 0; i < 4; i++)
         check({25'h0, i_taeu_mem_model.mem[20'h400 + i]},
               {25'h0, i[0] ? 8'hbe : 8'hef});
      run(1'b0, OP_FILL_UP, 32'h0, 32'h0);
      rd(OFS_A1, 32'h0404);
      // clock enable low stalls the apb answer without losing it
      fork
         begin
            repeat (4) @(posedge mclk);
            ce <= 1'b1;
         end
      join_none
      ce <= 1'b0;
      rd(OFS_A1, 32'h0404);
      // mid-run reset clears the pointers, which must be reloaded
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(OFS_A1, 32'h0);
      give_verdict();
   end
endmodule : testbench

// ---- verilog/taeu_alu_if.sv ----
// taeu_alu_if: operands to, and results from, the divider and decimal adder
// assumes both helpers are purely combinational
`timescale 1ns/1ps
interface taeu_alu_if;
   import taeu_pkg::*;
   logic [31:0] opa;
   logic [31:0] opb;
   logic word;
   taeu_div_t div_kind;
   logic [31:0] div_res;
   logic div_ovf;
   logic bcd_sub;
   logic bcd_cin;
   logic [15:0] bcd_res;
   logic bcd_cout;
   modport core_mp (output opa, opb, word, div_kind, bcd_sub, bcd_cin,
                    input div_res, div_ovf, bcd_res, bcd_cout);
   modport div_mp (input opa, opb, word, div_kind, output div_res, div_ovf);
   modport bcd_mp (input opa, opb, word, bcd_sub, bcd_cin, output bcd_res, bcd_cout);
endinterface : taeu_alu_if

// ---- verilog/taeu_bcd_adder.sv ----
// taeu_bcd_adder: four-digit packed decimal add, subtract by nines complement
// assumes a carry-in of 1 means no borrow when subtracting
`timescale 1ns/1ps
module taeu_bcd_adder (
   taeu_alu_if.bcd_mp alu
);
   import taeu_pkg::*;
   logic [4:0] c;

   assign c[0] = alu.bcd_cin;
   // one decimal digit per nibble, adjusted by six past nine
   for (genvar i = 0; i < 4; i++) begin : g_dig
      logic [3:0] bd;
      logic [4:0] sum;
      assign bd = alu.bcd_sub ? 4'h9 - alu.opa[4*i +: 4] : alu.opa[4*i +: 4];
      assign sum = {1'b0, alu.opb[4*i +: 4]} + {1'b0, bd} + {4'h0, c[i]};
      assign c[i+1] = sum > 5'h09;
      assign alu.bcd_res[4*i +: 4] = c[i+1] ? sum[3:0] + 4'h6 : sum[3:0];
   end
   // byte size carries out of the second digit
   assign alu.bcd_cout = alu.word ? c[4] : c[2];
endmodule : taeu_bcd_adder

// ---- verilog/taeu_core.sv ----
// taeu_core: transfer and arithmetic execution unit behind an apb slave
// assumes a single-word memory master port answered by same-clock logic
`timescale 1ns/1ps
module taeu_core (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [taeu_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [taeu_pkg::MADDR_W-1:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic mem_word,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic mem_ack
);
   import taeu_pkg::*;

   taeu_alu_if alu ();
   taeu_divider u_div (.alu(alu));
   taeu_bcd_adder u_bcd (.alu(alu));

   taeu_state_t st_reg, st_next;
   taeu_op_t op_reg, op_next;
   logic word_reg, word_next, done_reg, done_next;
   logic [31:0] opa_reg, opa_next, opb_reg, opb_next, res_reg, res_next;
   logic [3:0] flg_reg, flg_next;
   logic [15:0] a0_reg, a0_next, a1_reg, a1_next, cnt_reg, cnt_next;
   logic [15:0] r0_reg, r0_next, mwd_next;
   logic [7:0] bank_reg, bank_next;
   logic [31:0] prdata_next;
   logic pready_next, pslverr_next, mrd_next, mwr_next;
   logic [MADDR_W-1:0] maddr_next, src_addr, src_step;
   logic [15:0] step, a1_step;
   logic signed [15:0] mul_sb;
   logic signed [31:0] mul_sw;
   logic [31:0] mul_u;
   logic [15:0] bres;

   // offsets that answer without error
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = a[1:0] == 2'b00 && a <= OFS_R0;
   endfunction : reg_hit

   // helpers see the live operands every cycle
   assign alu.opa = opa_reg;
   assign alu.opb = opb_reg;
   assign alu.word = word_reg;
   assign alu.div_kind = op_reg == OP_DIV_S ? DIV_DVD_SIGN :
                         op_reg == OP_DIV_X ? DIV_DVS_SIGN : DIV_UNS;
   assign alu.bcd_sub = op_reg == OP_BCD_SUB || op_reg == OP_BCD_SBB;
   // plain subtract means no borrow in, plain add means no carry
   assign alu.bcd_cin = (op_reg == OP_BCD_ADC || op_reg == OP_BCD_SBB) ? flg_reg[FLG_C]
                        : alu.bcd_sub;

   // source is the bank nibble over the first address
   assign src_addr = {bank_reg[3:0], a0_reg};
   assign step = word_reg ? 16'h0002 : 16'h0001;
   assign src_step = op_reg == OP_COPY_DN ? src_addr - {4'h0, step}
                                          : src_addr + {4'h0, step};
   assign a1_step = op_reg == OP_COPY_DN ? a1_reg - step : a1_reg + step;
   assign bres = word_reg ? alu.bcd_res : {8'h00, alu.bcd_res[7:0]};

   // all next values: apb access, command execution, block transfer
   always_comb begin
      st_next = st_reg;
      op_next = op_reg;
      word_next = word_reg;
      done_next = done_reg;
      opa_next = opa_reg;
      opb_next = opb_reg;
      res_next = res_reg;
      flg_next = flg_reg;
      a0_next = a0_reg;
      a1_next = a1_reg;
      cnt_next = cnt_reg;
      r0_next = r0_reg;
      bank_next = bank_reg;
      prdata_next = prdata;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      maddr_next = mem_addr;
      mrd_next = 1'b0;
      mwr_next = 1'b0;
      mwd_next = mem_wdata;
      // operands widened first so the product keeps its upper half
      mul_sb = 16'($signed(opa_reg[7:0])) * 16'($signed(opb_reg[7:0]));
      mul_sw = 32'($signed(opa_reg[15:0])) * 32'($signed(opb_reg[15:0]));
      mul_u = word_reg ? {16'h0, opa_reg[15:0]} * {16'h0, opb_reg[15:0]}
                       : {16'h0, {8'h0, opa_reg[7:0]} * {8'h0, opb_reg[7:0]}};
      // first access cycle: decode, load read data, answer next edge
      if (psel && penable && !pready) begin
         pready_next = 1'b1;
         pslverr_next = !reg_hit(paddr) || (pwrite && st_reg != ST_IDLE);
         case (paddr)
            OFS_OPA: prdata_next = opa_reg;
            OFS_OPB: prdata_next = opb_reg;
            OFS_RES: prdata_next = res_reg;
            OFS_FLG: prdata_next = {28'h0, flg_reg};
            OFS_STAT: prdata_next = {30'h0, done_reg, st_reg != ST_IDLE};
            OFS_A0: prdata_next = {16'h0, a0_reg};
            OFS_A1: prdata_next = {16'h0, a1_reg};
            OFS_CNT: prdata_next = {16'h0, cnt_reg};
            OFS_BANK: prdata_next = {24'h0, bank_reg};
            OFS_R0: prdata_next = {16'h0, r0_reg};
            default: prdata_next = 32'h0;
         endcase
      end
      // write lands at the completing edge; refused while busy
      if (psel && penable && pready && pwrite && !pslverr) begin
         case (paddr)
            OFS_CMD: begin
               op_next = taeu_op_t'(pwdata[CMD_OP_LSB +: 5]);
               word_next = pwdata[CMD_WORD_BIT];
               done_next = 1'b0;
               st_next = ST_EXEC;
            end
            OFS_OPA: opa_next = pwdata;
            OFS_OPB: opb_next = pwdata;
            OFS_FLG: flg_next = pwdata[3:0];
            OFS_A0: a0_next = pwdata[15:0];
            OFS_A1: a1_next = pwdata[15:0];
            OFS_CNT: cnt_next = pwdata[15:0];
            OFS_BANK: bank_next = pwdata[7:0];
            OFS_R0: r0_next = pwdata[15:0];
            default: ;
         endcase
      end
      case (st_reg)
         ST_EXEC: begin
            st_next = ST_IDLE;
            done_next = 1'b1;
            case (op_reg)
               // nibble moves keep the other half of the destination
               OP_NIB_UU: res_next = {24'h0, opa_reg[7:4], opb_reg[3:0]};
               OP_NIB_UL: res_next = {24'h0, opb_reg[7:4], opa_reg[7:4]};
               OP_NIB_LU: res_next = {24'h0, opa_reg[3:0], opb_reg[3:0]};
               OP_NIB_LL: res_next = {24'h0, opb_reg[7:4], opa_reg[3:0]};
               // immediate byte stored or destination kept; select stores the low byte of opa or of opb
               OP_ST_Z: res_next = flg_reg[FLG_Z] ? {24'h0, opa_reg[7:0]} : opb_reg;
               OP_ST_NZ: res_next = !flg_reg[FLG_Z] ? {24'h0, opa_reg[7:0]} : opb_reg;
               OP_ST_SEL: res_next = {24'h0, flg_reg[FLG_Z] ? opa_reg[7:0] : opb_reg[7:0]};
               // products replace the destination, flags untouched
               OP_MUL_S: res_next = word_reg ? mul_sw : {16'h0, mul_sb};
               OP_MUL_U: res_next = mul_u;
               OP_DIV_S, OP_DIV_X, OP_DIV_U: begin
                  // overflow leaves the destination as it was
                  if (!alu.div_ovf)
                     res_next = alu.div_res;
                  flg_next[FLG_O] = alu.div_ovf;
               end
               OP_BCD_ADD, OP_BCD_ADC, OP_BCD_SUB, OP_BCD_SBB: begin
                  res_next = {16'h0, bres};
                  flg_next[FLG_C] = alu.bcd_cout;
                  flg_next[FLG_Z] = bres == 16'h0;
                  flg_next[FLG_S] = word_reg ? bres[15] : bres[7];
               end
               OP_COPY_UP, OP_COPY_DN, OP_FILL_UP: begin
                  // a zero count moves nothing
                  if (cnt_reg != 16'h0) begin
                     done_next = 1'b0;
                     if (op_reg == OP_FILL_UP) begin
                        st_next = ST_WRITE;
                        mwr_next = 1'b1;
                        maddr_next = {4'h0, a1_reg};
                        mwd_next = r0_reg;
                     end else begin
                        st_next = ST_READ;
                        mrd_next = 1'b1;
                        maddr_next = src_addr;
                     end
                  end
               end
               default: ;
            endcase
         end
         ST_READ: begin
            if (mem_ack) begin
               st_next = ST_WRITE;
               mwr_next = 1'b1;
               maddr_next = {4'h0, a1_reg};
               mwd_next = word_reg ? mem_rdata : {8'h00, mem_rdata[7:0]};
            end else
               mrd_next = 1'b1;
         end
         ST_WRITE: begin
            if (mem_ack) begin
               // one element done: step pointers, count down
               a1_next = a1_step;
               cnt_next = cnt_reg - 16'h0001;
               if (op_reg != OP_FILL_UP) begin
                  a0_next = src_step[15:0];
                  bank_next = {bank_reg[7:4], src_step[19:16]};
               end
               if (cnt_reg == 16'h0001) begin
                  st_next = ST_IDLE;
                  done_next = 1'b1;
               end else if (op_reg == OP_FILL_UP) begin
                  mwr_next = 1'b1;
                  maddr_next = {4'h0, a1_step};
               end else begin
                  st_next = ST_READ;
                  mrd_next = 1'b1;
                  maddr_next = src_step;
               end
            end else
               mwr_next = 1'b1;
         end
         default: ;
      endcase
   end

   // state register; ce low freezes everything
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;
         op_reg <= OP_NIB_UU;
         word_reg <= 1'b0;
         done_reg <= 1'b0;
         opa_reg <= RST_WORD;
         opb_reg <= RST_WORD;
         res_reg <= RST_WORD;
         flg_reg <= RST_FLG;
         a0_reg <= RST_HALF;
         a1_reg <= RST_HALF;
         cnt_reg <= RST_HALF;
         r0_reg <= RST_HALF;
         bank_reg <= RST_BYTE;
         prdata <= RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
         mem_addr <= '0;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_word <= 1'b0;
         mem_wdata <= RST_HALF;
      end else if (ce) begin
         st_reg <= st_next;
         op_reg <= op_next;
         word_reg <= word_next;
         done_reg <= done_next;
         opa_reg <= opa_next;
         opb_reg <= opb_next;
         res_reg <= res_next;
         flg_reg <= flg_next;
         a0_reg <= a0_next;
         a1_reg <= a1_next;
         cnt_reg <= cnt_next;
         r0_reg <= r0_next;
         bank_reg <= bank_next;
         prdata <= prdata_next;
         pready <= pready_next;
         pslverr <= pslverr_next;
         mem_addr <= maddr_next;
         mem_rd <= mrd_next;
         mem_wr <= mwr_next;
         mem_word <= word_next;
         mem_wdata <= mwd_next;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_exec(taeu_op_t o);
      ce && st_reg == ST_EXEC && op_reg == o;
   endsequence
   sequence s_elem_done;
      ce && st_reg == ST_WRITE && mem_ack;
   endsequence

   a_nib_lowlow: assert property (s_exec(OP_NIB_LL) |=>
      res_reg[7:0] == {$past(opb_reg[7:4]), $past(opa_reg[3:0])})
      else $error("nibble low move wrong");
   a_stz_keep: assert property (s_exec(OP_ST_Z) and !flg_reg[FLG_Z] |=>
      res_reg == $past(opb_reg))
      else $error("store on zero changed dest");
   a_sel_store: assert property (s_exec(OP_ST_SEL) |=>
      res_reg[7:0] == ($past(flg_reg[FLG_Z]) ? $past(opa_reg[7:0]) : $past(opb_reg[7:0])))
      else $error("select store picked wrong source");
   a_mul_flags: assert property ((s_exec(OP_MUL_S) or s_exec(OP_MUL_U)) |=>
      $stable(flg_reg))
      else $error("multiply changed flags");
   a_div_flags: assert property ((s_exec(OP_DIV_S) or s_exec(OP_DIV_X) or s_exec(OP_DIV_U))
      |=> flg_reg[2:0] == $past(flg_reg[2:0]))
      else $error("divide changed non-overflow flag");
   a_bcd_zero: assert property ((s_exec(OP_BCD_ADD) or s_exec(OP_BCD_SUB)) |=>
      flg_reg[FLG_Z] == (res_reg == 32'h0))
      else $error("decimal zero flag wrong");
   a_copy_src: assert property (ce && st_reg == ST_READ && mem_rd |->
      mem_addr == src_addr)
      else $error("copy source address wrong");
   a_count_dec: assert property (s_elem_done |=>
      cnt_reg == $past(cnt_reg) - 16'h0001)
      else $error("count not decremented");
   a_dst_step: assert property (s_elem_done and op_reg == OP_COPY_DN |=>
      a1_reg == $past(a1_reg) - (word_reg ? 16'h0002 : 16'h0001))
      else $error("down copy step wrong");
   a_last_elem: assert property (s_elem_done and cnt_reg == 16'h0001 |=>
      st_reg == ST_IDLE ##0 done_reg)
      else $error("block op did not finish");
endmodule : taeu_core

// ---- verilog/taeu_divider.sv ----
// taeu_divider: combinational byte/word divide, three remainder conventions
// assumes dividend in opb, divisor in opa, sampled by the core the same cycle
`timescale 1ns/1ps
module taeu_divider (
   taeu_alu_if.div_mp alu
);
   import taeu_pkg::*;
   logic sgn;
   logic signed [32:0] dvd, dvs, q, r;
   logic [32:0] ad, as, q0, r0;

   // sign-magnitude divide, then fix signs per convention
   always_comb begin
      sgn = alu.div_kind != DIV_UNS;
      dvd = alu.word ? {sgn & alu.opb[31], alu.opb}
                     : {{17{sgn & alu.opb[15]}}, alu.opb[15:0]};
      dvs = alu.word ? {{17{sgn & alu.opa[15]}}, alu.opa[15:0]}
                     : {{25{sgn & alu.opa[7]}}, alu.opa[7:0]};
      ad = dvd[32] ? 33'(-dvd) : dvd;
      as = dvs[32] ? 33'(-dvs) : dvs;
      q0 = (as == 33'h0) ? 33'h0 : ad / as;
      r0 = (as == 33'h0) ? 33'h0 : ad % as;
      // truncation toward zero, remainder follows dividend
      q = (dvd[32] ^ dvs[32]) ? -$signed(q0) : $signed(q0);
      r = dvd[32] ? -$signed(r0) : $signed(r0);
      // remainder moved to the divisor's sign, quotient floors
      if (alu.div_kind == DIV_DVS_SIGN && r != 33'sh0 && r[32] != dvs[32]) begin
         q = q - 33'sh1;
         r = r + dvs;
      end
      // overflow when divisor is zero or quotient leaves its size
      if (alu.word)
         alu.div_ovf = (as == 33'h0) ||
            (sgn ? (q[32:15] != {18{q[15]}}) : (q[32:16] != 17'h0));
      else
         alu.div_ovf = (as == 33'h0) ||
            (sgn ? (q[32:7] != {26{q[7]}}) : (q[32:8] != 25'h0));
      alu.div_res = alu.word ? {r[15:0], q[15:0]} : {16'h0, r[7:0], q[7:0]};
   end
endmodule : taeu_divider

// ---- verilog/taeu_pkg.sv ----
// taeu_pkg: register map, flag layout, opcodes and states of the exec unit
// assumes a 32-bit apb with byte addresses and a 20-bit memory space
package taeu_pkg;
   localparam int ADDR_W = 8;
   localparam int MADDR_W = 20;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_OPA = 8'h04;
   localparam logic [7:0] OFS_OPB = 8'h08;
   localparam logic [7:0] OFS_RES = 8'h0c;
   localparam logic [7:0] OFS_FLG = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   localparam logic [7:0] OFS_A0 = 8'h18;
   localparam logic [7:0] OFS_A1 = 8'h1c;
   localparam logic [7:0] OFS_CNT = 8'h20;
   localparam logic [7:0] OFS_BANK = 8'h24;
   localparam logic [7:0] OFS_R0 = 8'h28;
   // command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_WORD_BIT = 8;
   // flag register bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_S = 2;
   localparam int FLG_O = 3;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [3:0] RST_FLG = 4'h0;
   localparam logic [15:0] RST_HALF = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;

   typedef enum logic [4:0] {
      OP_NIB_UU = 5'h00, OP_NIB_UL = 5'h01, OP_NIB_LU = 5'h02, OP_NIB_LL = 5'h03,
      OP_ST_Z = 5'h04, OP_ST_NZ = 5'h05, OP_ST_SEL = 5'h06,
      OP_COPY_UP = 5'h07, OP_COPY_DN = 5'h08, OP_FILL_UP = 5'h09,
      OP_MUL_S = 5'h0a, OP_MUL_U = 5'h0b,
      OP_DIV_S = 5'h0c, OP_DIV_X = 5'h0d, OP_DIV_U = 5'h0e,
      OP_BCD_ADD = 5'h0f, OP_BCD_ADC = 5'h10, OP_BCD_SUB = 5'h11, OP_BCD_SBB = 5'h12
   } taeu_op_t;

   typedef enum logic [1:0] {
      DIV_DVD_SIGN = 2'b00, DIV_DVS_SIGN = 2'b01, DIV_UNS = 2'b10
   } taeu_div_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_READ = 2'b10, ST_WRITE = 2'b11
   } taeu_state_t;
endpackage : taeu_pkg
